//--- hdl/cpc_pin_ctrl.v
`timescale 1ns/1ps
// Overview of operation
// - Charge-status pin pulled low while a charge cycle runs.
// - Charge-status pin released when charging is complete or disabled.
// - Any fault makes the charge-status pin blink at one hertz.
// - Status-output-disable bit stops all driving of the charge-status pin.
// - Status change or fault gives one 256 us low pulse on alert pin.
// - Boost only with config bit set, request pin high, no supply.
// - Charging needs config bit set and charge enable pin low.
// - Applied limit is lower of register and pin limit when pin enabled.
// - Charging suspends while thermistor reads outside its window.
// - In ship mode, wake button held for ship hold turns switch on.
// - No supply, button held for reset hold: switch off, then on again.
// - Mux select driven low while data-line detection runs.
// - Mux select stays low after detection finds high-voltage adapter.
// - Mux select released after detection finds any other source.
// - Detection order: contact, primary, secondary, then high-voltage adapter.
// - Alert pulse raised on the clock edge after a fault appears, unless a pulse is already running.
`include "cpc_defs.vh"

module cpc_pin_ctrl #(
	parameter FAULT_W = 4,
	parameter BLINK_HALF_CYC = `CPC_CLK_MHZ * 1000000 / (2 * `CPC_BLINK_HZ),
	parameter ALERT_CYC = `CPC_ALERT_US * `CPC_CLK_MHZ,
	parameter SHIP_HOLD_CYC = `CPC_SHIP_HOLD_MS * `CPC_CYC_PER_MS,
	parameter RST_HOLD_CYC = `CPC_RST_HOLD_MS * `CPC_CYC_PER_MS,
	parameter SW_OFF_CYC = `CPC_SW_OFF_MS * `CPC_CYC_PER_MS
) (
	input wire pclk, // Bus clock
	input wire presetn, // Async reset, active low
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [7:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output wire pready, // APB ready
	output wire pslverr, // APB error, unmapped address
	output wire irq, // Level interrupt
	input wire supply_present, // Input source present
	input wire charge_done, // Charge cycle terminated
	input wire [FAULT_W-1:0] fault_in, // Fault flags
	input wire therm_hot, // Thermistor above window
	input wire therm_cold, // Thermistor below window
	input wire boost_request_pin, // Boost request pin
	input wire charge_enable_n, // Charge enable pin
	input wire [5:0] input_limit_pin, // Pin-derived limit code
	input wire wake_button_n, // Wake button, low when pressed
	input wire det_step_done, // Detection step finished
	input wire det_hv_found, // High-voltage adapter seen
	output wire stat_o, // Charge-status pin level
	output reg stat_oe, // Charge-status pin drive
	output wire alert_o, // Alert pin level
	output reg alert_oe, // Alert pin drive
	output wire data_line_mux_select_o, // Mux select level
	output reg data_line_mux_select_oe, // Mux select drive
	output reg battery_switch, // Battery switch on
	output reg boost_en, // Boost converter on
	output reg charge_en, // Charger on
	output reg [5:0] applied_limit // Applied input limit
);

	localparam [5:0] DET_IDLE = 6'h01;
	localparam [5:0] DET_CONTACT = 6'h02;
	localparam [5:0] DET_PRIMARY = 6'h04;
	localparam [5:0] DET_SECOND = 6'h08;
	localparam [5:0] DET_HV = 6'h10;
	localparam [5:0] DET_DONE = 6'h20;

	localparam [2:0] SW_ON = 3'h1;
	localparam [2:0] SW_SHIP = 3'h2;
	localparam [2:0] SW_RESET = 3'h4;

	localparam [31:0] BLINK_LAST = BLINK_HALF_CYC - 1;
	localparam [31:0] ALERT_LAST = ALERT_CYC - 1;
	localparam [31:0] SHIP_HOLD = SHIP_HOLD_CYC;
	localparam [31:0] RST_HOLD = RST_HOLD_CYC;
	localparam [31:0] SW_OFF_LAST = SW_OFF_CYC - 1;

	reg [4:0] ctrl_ff;
	reg [5:0] limit_ff;
	reg [4:0] irq_stat_ff;
	reg [4:0] irq_mask_ff;
	reg [5:0] det_ff;
	reg hv_ff;
	reg [2:0] sw_ff;
	reg [31:0] blink_cnt_ff;
	reg blink_ff;
	reg [31:0] alert_cnt_ff;
	reg [31:0] hold_cnt_ff;
	reg [31:0] off_cnt_ff;
	reg supply_ff;
	reg fault_ff;
	reg charging_ff;
	reg boost_prev_ff;

	reg [5:0] nxt_det;
	reg nxt_hv;
	reg [2:0] nxt_sw;
	reg [31:0] nxt_off_cnt;
	reg [4:0] nxt_irq_stat;
	reg [31:0] rd_data;
	reg rd_hit;

	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire wr_ctrl = access & pwrite & (paddr == `CPC_OFS_CTRL);
	wire wr_limit = access & pwrite & (paddr == `CPC_OFS_LIMIT);
	wire wr_mask = access & pwrite & (paddr == `CPC_OFS_IRQ_MASK);
	wire rd_irq = access & ~pwrite & (paddr == `CPC_OFS_IRQ_STAT);

	wire any_fault = |fault_in;
	wire temp_out = therm_hot | therm_cold;
	wire in_ship = (sw_ff == SW_SHIP);

	// Qualified enables
	wire chg_allowed = ctrl_ff[`CPC_CTRL_CHARGE_CFG] & ~charge_enable_n
		& ~temp_out;
	wire charging = chg_allowed & supply_present & ~charge_done
		& ~in_ship;
	wire boost_req = ctrl_ff[`CPC_CTRL_BOOST_CFG] & boost_request_pin
		& ~supply_present;
	wire [5:0] limit_sel = (ctrl_ff[`CPC_CTRL_LIMIT_PIN_EN]
		&& (input_limit_pin < limit_ff)) ? input_limit_pin : limit_ff;

	// Button hold and switch-off time thresholds
	wire ship_trig = in_ship & (hold_cnt_ff == SHIP_HOLD);
	wire rst_trig = (sw_ff == SW_ON) & ~supply_present
		& (hold_cnt_ff == RST_HOLD);
	wire off_end = (sw_ff == SW_RESET) & (off_cnt_ff == SW_OFF_LAST);

	// Events
	wire [4:0] events;
	assign events[`CPC_EV_STATUS] = (charging != charging_ff)
		| (boost_en != boost_prev_ff);
	assign events[`CPC_EV_FAULT] = any_fault & ~fault_ff;
	assign events[`CPC_EV_DET_DONE] = (det_ff == DET_HV) & det_step_done;
	assign events[`CPC_EV_SHIP_EXIT] = ship_trig;
	assign events[`CPC_EV_SYS_RESET] = off_end;

	assign pready = 1'b1;
	assign pslverr = access & ~rd_hit;
	assign irq = |(irq_stat_ff & irq_mask_ff);
	assign stat_o = 1'b0;
	assign alert_o = 1'b0;
	assign data_line_mux_select_o = 1'b0;

	always @* begin
		rd_hit = 1'b1;
		rd_data = 32'h00000000;
		case (paddr)
		`CPC_OFS_CTRL: rd_data[4:0] = ctrl_ff;
		`CPC_OFS_LIMIT: rd_data[5:0] = limit_ff;
		`CPC_OFS_STATUS: begin
			rd_data[`CPC_ST_CHARGING] = charging_ff;
			rd_data[`CPC_ST_BOOST] = boost_en;
			rd_data[`CPC_ST_TEMP_SUSP] = temp_out;
			rd_data[`CPC_ST_SHIP] = in_ship;
			rd_data[`CPC_ST_SWITCH_ON] = battery_switch;
			rd_data[`CPC_ST_FAULT] = fault_ff;
			rd_data[`CPC_ST_DET_DONE] = (det_ff == DET_DONE);
			rd_data[`CPC_ST_HV_FOUND] = hv_ff;
			rd_data[`CPC_ST_LIMIT_LSB +: 6] = applied_limit;
		end
		`CPC_OFS_IRQ_STAT: rd_data[4:0] = irq_stat_ff;
		`CPC_OFS_IRQ_MASK: rd_data[4:0] = irq_mask_ff;
		default: rd_hit = 1'b0;
		endcase
	end

	// Set wins over a read-clear in the same cycle
	always @* begin
		nxt_irq_stat = (rd_irq ? 5'h00 : irq_stat_ff) | events;
	end

	// Data-line detection sequence
	always @* begin
		nxt_det = det_ff;
		nxt_hv = hv_ff;
		case (det_ff)
		DET_IDLE: begin
			nxt_hv = 1'b0;
			if (supply_present & ~supply_ff)
				nxt_det = DET_CONTACT;
		end
		DET_CONTACT: begin
			if (det_step_done)
				nxt_det = DET_PRIMARY;
		end
		DET_PRIMARY: begin
			if (det_step_done)
				nxt_det = DET_SECOND;
		end
		DET_SECOND: begin
			if (det_step_done)
				nxt_det = DET_HV;
		end
		DET_HV: begin
			if (det_step_done) begin
				nxt_det = DET_DONE;
				nxt_hv = det_hv_found;
			end
		end
		DET_DONE: nxt_det = DET_DONE;
		default: nxt_det = DET_IDLE;
		endcase
		if (~supply_present) begin
			nxt_det = DET_IDLE;
			nxt_hv = 1'b0;
		end
	end

	// Battery switch sequencing
	always @* begin
		nxt_sw = sw_ff;
		nxt_off_cnt = 32'h00000000;
		case (sw_ff)
		SW_ON: begin
			if (wr_ctrl & pwdata[`CPC_CTRL_SHIP_ENTER])
				nxt_sw = SW_SHIP;
			else if (rst_trig)
				nxt_sw = SW_RESET;
		end
		SW_SHIP: begin
			if (ship_trig)
				nxt_sw = SW_ON;
		end
		SW_RESET: begin
			nxt_off_cnt = off_cnt_ff + 32'h00000001;
			if (off_end)
				nxt_sw = SW_ON;
		end
		default: nxt_sw = SW_ON;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= `CPC_CTRL_RST;
			limit_ff <= `CPC_LIMIT_RST;
			irq_mask_ff <= `CPC_IRQ_MASK_RST;
			irq_stat_ff <= 5'h00;
			prdata <= 32'h00000000;
		end else begin
			if (wr_ctrl)
				ctrl_ff <= {1'b0, pwdata[3:0]};
			if (wr_limit)
				limit_ff <= pwdata[5:0];
			if (wr_mask)
				irq_mask_ff <= pwdata[4:0];
			irq_stat_ff <= nxt_irq_stat;
			// Sampled in setup so the access phase sees stable data
			if (setup)
				prdata <= rd_data;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			det_ff <= DET_IDLE;
			hv_ff <= 1'b0;
			sw_ff <= SW_ON;
			off_cnt_ff <= 32'h00000000;
			supply_ff <= 1'b0;
			fault_ff <= 1'b0;
			charging_ff <= 1'b0;
			boost_prev_ff <= 1'b0;
			data_line_mux_select_oe <= 1'b0;
			battery_switch <= 1'b1;
			boost_en <= 1'b0;
			charge_en <= 1'b0;
			applied_limit <= `CPC_LIMIT_RST;
		end else begin
			det_ff <= nxt_det;
			hv_ff <= nxt_hv;
			sw_ff <= nxt_sw;
			off_cnt_ff <= nxt_off_cnt;
			supply_ff <= supply_present;
			fault_ff <= any_fault;
			charging_ff <= charging;
			boost_prev_ff <= boost_en;
			data_line_mux_select_oe <= ((nxt_det != DET_IDLE)
				& (nxt_det != DET_DONE))
				| ((nxt_det == DET_DONE) & nxt_hv);
			battery_switch <= (nxt_sw == SW_ON);
			boost_en <= boost_req;
			charge_en <= chg_allowed & ~in_ship;
			applied_limit <= limit_sel;
		end
	end

	// Button hold timer; saturates so each press fires once
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_cnt_ff <= 32'h00000000;
		end else if (wake_button_n) begin
			hold_cnt_ff <= 32'h00000000;
		end else if (hold_cnt_ff != 32'hFFFFFFFF) begin
			hold_cnt_ff <= hold_cnt_ff + 32'h00000001;
		end
	end

	// Blink timebase; runs only while a fault is present, held cleared otherwise
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt_ff <= 32'h00000000;
			blink_ff <= 1'b0;
		end else if (~any_fault) begin
			blink_cnt_ff <= 32'h00000000;
			blink_ff <= 1'b0;
		end else if (blink_cnt_ff == BLINK_LAST) begin
			blink_cnt_ff <= 32'h00000000;
			blink_ff <= ~blink_ff;
		end else begin
			blink_cnt_ff <= blink_cnt_ff + 32'h00000001;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_oe <= 1'b0;
		end else if (ctrl_ff[`CPC_CTRL_STATUS_OUTPUT_DISABLE]) begin
			stat_oe <= 1'b0;
		end else if (any_fault) begin
			stat_oe <= ~blink_ff;
		end else begin
			stat_oe <= charging;
		end
	end

	// Alert pulse; events during a pulse do not stretch it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alert_oe <= 1'b0;
			alert_cnt_ff <= 32'h00000000;
		end else if (alert_oe) begin
			if (alert_cnt_ff == ALERT_LAST) begin
				alert_oe <= 1'b0;
				alert_cnt_ff <= 32'h00000000;
			end else begin
				alert_cnt_ff <= alert_cnt_ff + 32'h00000001;
			end
		end else if (|events) begin
			alert_oe <= 1'b1;
			alert_cnt_ff <= 32'h00000000;
		end
	end

endmodule // cpc_pin_ctrl

//--- hdl/cpc_defs.vh
`ifndef CPC_DEFS_VH
`define CPC_DEFS_VH

// Register byte offsets
`define CPC_OFS_CTRL 8'h00
`define CPC_OFS_LIMIT 8'h04
`define CPC_OFS_STATUS 8'h08
`define CPC_OFS_IRQ_STAT 8'h0C
`define CPC_OFS_IRQ_MASK 8'h10

// Control register fields
`define CPC_CTRL_STATUS_OUTPUT_DISABLE 0
`define CPC_CTRL_BOOST_CFG 1
`define CPC_CTRL_CHARGE_CFG 2
`define CPC_CTRL_LIMIT_PIN_EN 3
`define CPC_CTRL_SHIP_ENTER 4
`define CPC_CTRL_RST 5'h06

// Limit register
`define CPC_LIMIT_W 6
`define CPC_LIMIT_RST 6'h08

// Status register fields
`define CPC_ST_CHARGING 0
`define CPC_ST_BOOST 1
`define CPC_ST_TEMP_SUSP 2
`define CPC_ST_SHIP 3
`define CPC_ST_SWITCH_ON 4
`define CPC_ST_FAULT 5
`define CPC_ST_DET_DONE 6
`define CPC_ST_HV_FOUND 7
`define CPC_ST_LIMIT_LSB 8

// Interrupt event bits
`define CPC_EV_W 5
`define CPC_EV_STATUS 0
`define CPC_EV_FAULT 1
`define CPC_EV_DET_DONE 2
`define CPC_EV_SHIP_EXIT 3
`define CPC_EV_SYS_RESET 4
`define CPC_IRQ_MASK_RST 5'h00

// Timing: figures in their own unit, cycles derived from the clock
`define CPC_CLK_MHZ 100
`define CPC_ALERT_US 256
`define CPC_BLINK_HZ 1
`define CPC_SHIP_HOLD_MS 1000
`define CPC_RST_HOLD_MS 10000
`define CPC_SW_OFF_MS 250
`define CPC_CYC_PER_MS (`CPC_CLK_MHZ * 1000)
`define CPC_CNT_W 32

`endif

//--- sim/cpc_pin_ctrl_checker.sv
`timescale 1ns/1ps
module cpc_pin_ctrl_checker #(
	parameter FAULT_W = 4,
	parameter RST_HOLD_CYC = 20
) (
	input wire pclk, // Clock
	input wire presetn, // Reset, active low
	input wire supply_present, // Supply seen
	input wire [FAULT_W-1:0] fault_in, // Faults
	input wire therm_hot, // Too hot
	input wire therm_cold, // Too cold
	input wire boost_request_pin, // Boost pin
	input wire charge_enable_n, // Charge pin
	input wire wake_button_n, // Button
	input wire stat_oe, // Status drive
	input wire alert_oe, // Alert drive
	input wire data_line_mux_select_oe, // Mux drive
	input wire battery_switch, // Switch on
	input wire boost_en, // Boost on
	input wire charge_en // Charger on
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	int low_ff;
	// Cycles the button has been held
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_ff <= 0;
		end else begin
			low_ff <= wake_button_n ? 0 : low_ff + 1;
		end
	end
	a_alert_width: assert property ($rose(alert_oe) |->
		alert_oe[*6] ##1 !alert_oe) else $error("alert width");
	a_fault_alert: assert property ($rose(|fault_in) && !alert_oe
		|-> ##[1:2] alert_oe) else $error("late alert");
	a_boost_gate: assert property (boost_en |->
		$past(boost_request_pin && !supply_present)) else $error("boost");
	a_charge_pin: assert property (charge_en |->
		$past(!charge_enable_n)) else $error("charge");
	a_therm_susp: assert property (charge_en |->
		!$past(therm_hot || therm_cold)) else $error("thermal");
	a_stat_steady: assert property (stat_oe && !$past(|fault_in) &&
		!$past(|fault_in, 2) |-> charge_en) else $error("stat");
	a_blink_half: assert property ($fell(stat_oe) ##0
		(|fault_in)[*8] |-> !stat_oe ##1 stat_oe) else $error("blink");
	a_reset_off: assert property ($fell(battery_switch) && !wake_button_n
		|-> !battery_switch[*5] ##1 battery_switch) else $error("off time");
	a_reset_hold: assert property ($fell(battery_switch) &&
		!wake_button_n |-> low_ff >= RST_HOLD_CYC) else $error("hold");
	a_mux_claim: assert property ($rose(data_line_mux_select_oe) |->
		$past(supply_present)) else $error("mux claim");
	c_reset: cover property ($fell(battery_switch));
	c_alert: cover property ($rose(alert_oe));
	c_mux: cover property ($rose(data_line_mux_select_oe));
endmodule // cpc_pin_ctrl_checker

bind cpc_pin_ctrl cpc_pin_ctrl_checker #(.FAULT_W(FAULT_W),
	.RST_HOLD_CYC(RST_HOLD_CYC)) i_chk (.pclk(pclk), .presetn(presetn),
	.supply_present(supply_present), .fault_in(fault_in),
	.therm_hot(therm_hot), .therm_cold(therm_cold),
	.boost_request_pin(boost_request_pin),
	.charge_enable_n(charge_enable_n), .wake_button_n(wake_button_n),
	.stat_oe(stat_oe), .alert_oe(alert_oe),
	.data_line_mux_select_oe(data_line_mux_select_oe),
	.battery_switch(battery_switch), .boost_en(boost_en),
	.charge_en(charge_en));

//--- sim/cpc_far_side.sv
`timescale 1ns/1ps
module cpc_far_side (
	input wire stat_oe, // Status drive
	input wire alert_oe, // Alert drive
	input wire mux_oe, // Mux select drive
	input wire press, // Button pressed
	output wire stat_pin, // Status line
	output wire alert_pin, // Alert line
	output wire data_line_mux_select_pin, // Mux select line
	output wire wake_button_n // Button line
);
	// Every line has a pull-up, so a release reads high
	assign stat_pin = !stat_oe;
	assign alert_pin = !alert_oe;
	assign data_line_mux_select_pin = !mux_oe;
	assign wake_button_n = !press;
endmodule // cpc_far_side

//--- sim/cpc_pin_ctrl_tb_top.sv
`timescale 1ns/1ps
module cpc_pin_ctrl_tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd, r;
	logic sup = 0, done = 0, hot = 0, cold = 0, breq = 0, cen_n = 1;
	logic detp = 0, hv = 0, press = 0, er;
	logic [3:0] flt = 4'h0;
	logic [5:0] lpin = 6'h3F, lim;
	wire [31:0] prdata;
	wire pready, pslverr, irq, so, soe, ao, aoe, mo, moe, bsw, bst, chg;
	wire wbn, stat_pin, alert_pin, data_line_mux_select_pin;
	int num_errors = 0, n_checks = 0, seed = 26007, n, ctrl = 6, lreg = 8;
	always #5 pclk = ~pclk;
	cpc_pin_ctrl #(.BLINK_HALF_CYC(8), .ALERT_CYC(6), .SHIP_HOLD_CYC(10),
		.RST_HOLD_CYC(20), .SW_OFF_CYC(5)) i_cpc_pin_ctrl (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .supply_present(sup),
		.charge_done(done), .fault_in(flt), .therm_hot(hot),
		.therm_cold(cold), .boost_request_pin(breq), .charge_enable_n(cen_n),
		.input_limit_pin(lpin), .wake_button_n(wbn), .det_step_done(detp),
		.det_hv_found(hv), .stat_o(so), .stat_oe(soe), .alert_o(ao),
		.alert_oe(aoe), .data_line_mux_select_o(mo),
		.data_line_mux_select_oe(moe), .battery_switch(bsw), .boost_en(bst),
		.charge_en(chg), .applied_limit(lim));
	cpc_far_side i_cpc_far_side (.stat_oe(soe), .alert_oe(aoe),
		.mux_oe(moe), .press(press), .stat_pin(stat_pin),
		.alert_pin(alert_pin), .data_line_mux_select_pin(data_line_mux_select_pin), .wake_button_n(wbn));
	task end_of_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			num_errors++;
			end_of_test;
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		// Let register updates of the access edge settle
		#1;
	endtask
	task wt(input int c);
		repeat (c) @(posedge pclk);
		#1;
	endtask
	task hold(input int c);
		@(posedge pclk) press <= 1;
		repeat (c) @(posedge pclk);
		press <= 0;
		wt(3);
	endtask
	task det(input logic h);
		@(posedge pclk) sup <= 0;
		hv <= h;
		wt(3);
		@(posedge pclk) sup <= 1;
		repeat (4) begin
			wt(3);
			cmp("data_line_mux_select", 0, data_line_mux_select_pin);
			@(posedge pclk) detp <= 1;
			@(posedge pclk) detp <= 0;
		end
		wt(3);
		cmp("data_line_mux_select end", !h, data_line_mux_select_pin);
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		apb(0, 8'h00, 0);
		cmp("ctrl rst", 32'h6, rd);
		cmp("slverr ok", 0, er);
		cmp("pin lvl", 0, {so, ao, mo});
		apb(0, 8'h04, 0);
		cmp("lim rst", 32'h8, rd);
		apb(0, 8'h14, 0);
		cmp("unmapped", 32'h0, rd);
		cmp("slverr", 1, er);
		repeat (8) begin
			r = $random(seed);
			@(posedge pclk) {hot, cold, breq, cen_n, done, sup} <= r[5:0];
			lpin <= r[11:6];
			ctrl = r[15:12];
			lreg = r[21:16];
			apb(1, 8'h00, ctrl);
			apb(1, 8'h04, lreg);
			apb(0, 8'h04, 0);
			cmp("lim rd", lreg, rd);
			wt(3);
			n = ctrl[2] & !cen_n & !hot & !cold;
			cmp("charge", n, chg);
			n = n & sup & !done & !ctrl[0];
			cmp("stat", !n, stat_pin);
			cmp("boost", ctrl[1] & breq & !sup, bst);
			n = (ctrl[3] && lpin < lreg) ? lpin : lreg;
			cmp("limit", n, lim);
		end
		det(1);
		apb(0, 8'h08, 0);
		cmp("det st", 2'b11, rd[7:6]);
		det(0);
		@(posedge pclk) sup <= 0;
		breq <= 0;
		apb(1, 8'h00, 7);
		apb(1, 8'h10, 2);
		apb(0, 8'h0C, 0);
		wt(30);
		@(posedge pclk) flt <= 4'h1;
		n = 0;
		repeat (32) begin
			wt(1);
			n += !alert_pin;
			cmp("stat off", 1, stat_pin);
		end
		cmp("alert len", 6, n);
		cmp("irq", 1, irq);
		apb(1, 8'h10, 0);
		cmp("irq masked", 0, irq);
		apb(1, 8'h00, 6);
		apb(1, 8'h10, 2);
		n = 0;
		repeat (32) begin
			wt(1);
			n += !stat_pin;
		end
		cmp("blink", 16, n);
		apb(0, 8'h0C, 0);
		cmp("irq stat", 1, rd[1]);
		cmp("irq clr", 0, irq);
		@(posedge pclk) flt <= 4'h0;
		apb(1, 8'h00, 8'h16);
		hold(5);
		hold(7);
		apb(0, 8'h08, 0);
		cmp("ship", 1, rd[3]);
		hold(12);
		apb(0, 8'h08, 0);
		cmp("ship exit", 0, rd[3]);
		cmp("switch", 1, bsw);
		@(posedge pclk) press <= 1;
		n = 0;
		repeat (40) begin
			wt(1);
			n += !bsw;
		end
		cmp("sw off", 5, n);
		@(posedge pclk) press <= 0;
		wt(5);
		end_of_test;
	end
endmodule // cpc_pin_ctrl_tb_top
